/* logic/bsw_status_reg.sv */
// bus status word register bank with an AHB-Lite slave and an abort interrupt
// assumes events are synchronous to ref_clk and the strap pin is asynchronous
//
// How it works
// [RQ1] bits 6..0 and bit 8 are reserved, no function
// [RQ2] bit 7 is a read-only fast back-to-back flag, reset value one
// [RQ3] bits 10..9 are read-only timing, loaded only from the strap at reset
// [RQ4] strap low gives timing 01, strap high gives timing 10
// [RQ5] strap level captured at reset reads back at bit 0 of readback register
// [RQ6] timing codes: 00 fast, 01 medium, 10 slow, 11 reserved
// [RQ7] bit 11 sets when we end a transaction as target with target-abort
// [RQ8] bit 12 sets when our master transaction gets a target-abort
// [RQ9] bit 13 sets when our master transaction ends with master-abort
// [RQ10] writing 4000h clears only bit 14, others keep their value
// [RQ11] reads are normal; writes only clear writable bits written as one
// [RQ12] reserved bits read zero; abort flags reset to zero and stay set
// [RQ13] writing zero to a flag bit leaves it unchanged
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module bsw_status_reg (
	input  wire logic               ref_clk,          // 40 MHz clock
	input  wire logic               resetn,           // synchronous reset, active low
	input  wire logic               timing_strap_pin, // strap pin, asynchronous
	input  wire bsw_pkg::bsw_events_s events,         // event pulses from bus engine
	input  wire logic               hsel,             // ahb slave select
	input  wire logic [7:0]         haddr,            // ahb byte address
	input  wire logic [1:0]         htrans,           // ahb transfer type
	input  wire logic               hwrite,           // ahb write
	input  wire logic [2:0]         hsize,            // ahb size, word only
	input  wire logic [31:0]        hwdata,           // ahb write data
	input  wire logic               hready,           // ahb bus ready
	output logic [31:0]             hrdata,           // ahb read data
	output logic                    hreadyout,        // always ready
	output logic                    hresp,            // always okay
	output logic                    irq,              // level interrupt
	output logic [1:0]              select_timing     // current timing field
);
	logic [15:0] status_r;      // writable flag bits 15..11
	logic [1:0]  timing_r;
	logic        strap_r;
	logic [1:0]  strap_sync_r;  // [0] first stage, [1] second
	logic        in_reset_r;
	logic [bsw_pkg::BSW_NUM_EV-1:0] ist_r;
	logic [bsw_pkg::BSW_NUM_EV-1:0] imask_r;
	logic        wr_pend_r;
	logic        rd_ist_r;
	logic [7:0]  addr_r;
	logic [15:0] status_view;
	logic [15:0] clr_mask;
	logic [15:0] set_mask;
	logic        addr_ok;
	logic [bsw_pkg::BSW_NUM_EV-1:0] ev_vec;

	// two flops before the strap is read
	always_ff @(posedge ref_clk) begin
		strap_sync_r <= {strap_sync_r[0], timing_strap_pin};
	end

	// capture the strap on every reset cycle and one edge past release, then freeze
	always_ff @(posedge ref_clk) begin
		in_reset_r <= ~resetn;
		if (~resetn || in_reset_r) begin
			strap_r  <= strap_sync_r[1]; // RQ5
			timing_r <= strap_sync_r[1] ? bsw_pkg::BSW_TIM_SLOW
			                            : bsw_pkg::BSW_TIM_MEDIUM; // RQ3 RQ4 RQ6
		end
	end

	assign ev_vec = events;
	// hardware sets, in the bit positions of the status word
	always_comb begin
		set_mask = 16'h0000;
		set_mask[bsw_pkg::BSW_STA_BIT]  = events.sig_target_abort; // RQ7
		set_mask[bsw_pkg::BSW_RTA_BIT]  = events.rcv_target_abort; // RQ8
		set_mask[bsw_pkg::BSW_RMA_BIT]  = events.rcv_master_abort; // RQ9
		set_mask[bsw_pkg::BSW_PERR_BIT] = events.det_perr;
		set_mask[bsw_pkg::BSW_SERR_BIT] = events.sig_serr;
	end

	// data phase write: ones clear writable bits, zeros do nothing
	assign clr_mask = (wr_pend_r && addr_r == bsw_pkg::BSW_OFF_STATUS)
	                  ? (hwdata[15:0] & bsw_pkg::BSW_W1C_MASK) : 16'h0000; // RQ10 RQ11 RQ13

	// flags: set wins over a same-cycle clear
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			status_r <= 16'h0000; // RQ12
		end else begin
			status_r <= ((status_r & ~clr_mask) | set_mask) & bsw_pkg::BSW_W1C_MASK; // RQ11 RQ12
		end
	end

	// assembled view; reserved bits forced to zero
	always_comb begin
		status_view = status_r; // RQ1 RQ12
		status_view[bsw_pkg::BSW_FBB_BIT] = bsw_pkg::BSW_FBB_RST; // RQ2
		status_view[bsw_pkg::BSW_TIM_HI:bsw_pkg::BSW_TIM_LO] = timing_r; // RQ3
	end

	assign addr_ok = hsel && hready && htrans == bsw_pkg::BSW_HTRANS_NONSEQ;

	// address phase capture; zero wait states so only one transfer is in flight
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wr_pend_r <= 1'b0;
			rd_ist_r  <= 1'b0;
			addr_r    <= 8'h00;
		end else begin
			wr_pend_r <= addr_ok && hwrite;
			rd_ist_r  <= addr_ok && !hwrite && haddr == bsw_pkg::BSW_OFF_IRQ_STAT;
			if (addr_ok) begin
				addr_r <= haddr;
			end
		end
	end

	// read data is registered in the address phase; unmapped reads give zero
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			hrdata <= 32'h00000000;
		end else if (addr_ok && !hwrite) begin
			case (haddr)
				bsw_pkg::BSW_OFF_STATUS:   hrdata <= {16'h0000, status_view}; // RQ11
				bsw_pkg::BSW_OFF_READBACK: hrdata <= {31'h00000000, strap_r}; // RQ5
				bsw_pkg::BSW_OFF_IRQ_STAT: hrdata <= {27'h0000000, ist_r};
				bsw_pkg::BSW_OFF_IRQ_MASK: hrdata <= {27'h0000000, imask_r};
				default:                   hrdata <= 32'h00000000;
			endcase
		end
	end

	// interrupt status: sticky, cleared by a read, new event wins
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			ist_r <= '0;
		end else begin
			ist_r <= (rd_ist_r ? '0 : ist_r) | ev_vec;
		end
	end

	// interrupt mask, written in the data phase
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			imask_r <= '0;
		end else if (wr_pend_r && addr_r == bsw_pkg::BSW_OFF_IRQ_MASK) begin
			imask_r <= hwdata[bsw_pkg::BSW_NUM_EV-1:0];
		end
	end

	// registered outputs
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			irq           <= 1'b0;
			hreadyout     <= 1'b1;
			hresp         <= 1'b0;
			select_timing <= bsw_pkg::BSW_TIM_MEDIUM;
		end else begin
			irq           <= |(ist_r & imask_r);
			hreadyout     <= 1'b1;
			hresp         <= 1'b0;
			select_timing <= timing_r;
		end
	end

	// checks
	// every property but AST_RST_CLEAR watches registered state on ref_clk and is muted while reset is held;
	// the flag checks look one edge past the cause because status_r is a plain register,
	// so a combinational shortcut added later would show up here as an early value
	// bus checks use the address phase inputs as the cause and hrdata as the effect,
	// which matches the zero wait state answer the host relies on
	// status word
	AST_TA_SET: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ7
		events.sig_target_abort |=> status_r[bsw_pkg::BSW_STA_BIT])
		else $error("signalled target abort not flagged");
	AST_RTA_SET: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ8
		events.rcv_target_abort |=> status_r[bsw_pkg::BSW_RTA_BIT])
		else $error("received target abort not flagged");
	AST_RMA_SET: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ9
		events.rcv_master_abort |=> status_r[bsw_pkg::BSW_RMA_BIT])
		else $error("received master abort not flagged");
	AST_STICKY: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ13
		(status_r[bsw_pkg::BSW_STA_BIT] && !clr_mask[bsw_pkg::BSW_STA_BIT])
		|=> status_r[bsw_pkg::BSW_STA_BIT])
		else $error("flag lost without a clear");
	AST_CLR_ONLY14: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ10
		(wr_pend_r && addr_r == bsw_pkg::BSW_OFF_STATUS && hwdata[15:0] == 16'h4000
		 && set_mask == 16'h0000)
		|=> status_r == ($past(status_r) & 16'hbfff))
		else $error("clearing bit 14 disturbed other bits");
	AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ1
		(status_view[6:0] == 7'h00) && !status_view[8])
		else $error("reserved bit nonzero");
	AST_FBB_ONE: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ2
		status_view[bsw_pkg::BSW_FBB_BIT])
		else $error("fast back-to-back flag not one");
	AST_TIM_STRAP: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ4
		timing_r == (strap_r ? 2'h2 : 2'h1))
		else $error("timing field does not match strap");
	AST_TIM_STABLE: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ3
		!in_reset_r |=> $stable(timing_r) && $stable(strap_r))
		else $error("timing changed outside reset");
	AST_RST_CLEAR: assert property (@(posedge ref_clk) // RQ12
		!resetn |=> status_r == 16'h0000)
		else $error("flags not cleared by reset");

	// a received target abort stays set until written with a one
	AST_RTA_STICKY: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ13
		(status_r[bsw_pkg::BSW_RTA_BIT] && !clr_mask[bsw_pkg::BSW_RTA_BIT]) |=> status_r[bsw_pkg::BSW_RTA_BIT])
		else $error("received target abort flag lost");

	// a received master abort stays set until written with a one
	AST_RMA_STICKY: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ13
		(status_r[bsw_pkg::BSW_RMA_BIT] && !clr_mask[bsw_pkg::BSW_RMA_BIT]) |=> status_r[bsw_pkg::BSW_RMA_BIT])
		else $error("received master abort flag lost");

	// parity flag keeps its value without a clear
	AST_PERR_STICKY: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ13
		(status_r[bsw_pkg::BSW_PERR_BIT] && !clr_mask[bsw_pkg::BSW_PERR_BIT]) |=> status_r[bsw_pkg::BSW_PERR_BIT])
		else $error("parity flag lost");

	// system error flag keeps its value without a clear
	AST_SERR_STICKY: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ13
		(status_r[bsw_pkg::BSW_SERR_BIT] && !clr_mask[bsw_pkg::BSW_SERR_BIT]) |=> status_r[bsw_pkg::BSW_SERR_BIT])
		else $error("system error flag lost");

	// without an event no flag may rise, so a write can never set one
	AST_NO_WR_SET: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ11
		(set_mask == 16'h0000) |=> ((status_r & ~$past(status_r)) == 16'h0000))
		else $error("flag rose without an event");

	// a one written to the signalled abort flag clears it
	AST_STA_CLR: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ11
		(clr_mask[bsw_pkg::BSW_STA_BIT] && !set_mask[bsw_pkg::BSW_STA_BIT]) |=> !status_r[bsw_pkg::BSW_STA_BIT])
		else $error("signalled abort flag not cleared");

	// a one written to bit 14 clears it
	AST_PERR_CLR: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ10
		(clr_mask[bsw_pkg::BSW_PERR_BIT] && !set_mask[bsw_pkg::BSW_PERR_BIT]) |=> !status_r[bsw_pkg::BSW_PERR_BIT])
		else $error("bit 14 not cleared");

	// a received master abort in the same cycle as a clear keeps its flag
	AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ11
		(set_mask[bsw_pkg::BSW_RMA_BIT] && clr_mask[bsw_pkg::BSW_RMA_BIT]) |=> status_r[bsw_pkg::BSW_RMA_BIT])
		else $error("clear beat a same-cycle event");

	// nothing below the flags is ever stored in the flag register
	AST_RSVD_REG: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ1
		status_r[10:0] == 11'h000)
		else $error("reserved bit stored");
	// bus side

	// a status read returns the assembled word with zero upper half
	AST_RD_STATUS: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ11
		(addr_ok && !hwrite && haddr == bsw_pkg::BSW_OFF_STATUS)
		|=> hrdata == {16'h0000, $past(status_view)})
		else $error("status read returned wrong word");

	// a readback read returns the captured strap alone
	AST_RD_STRAP: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ5
		(addr_ok && !hwrite && haddr == bsw_pkg::BSW_OFF_READBACK)
		|=> hrdata == {31'h00000000, $past(strap_r)})
		else $error("strap readback wrong");

	// reads past the map return zero
	AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!resetn)
		(addr_ok && !hwrite && haddr > bsw_pkg::BSW_OFF_IRQ_MASK) |=> hrdata == 32'h00000000)
		else $error("unmapped read not zero");

	// the slave never stalls and never errors
	AST_READY_OKAY: assert property (@(posedge ref_clk) disable iff (!resetn)
		hreadyout && !hresp)
		else $error("slave stalled or errored");

	// mask write lands in the data phase
	AST_MASK_WR: assert property (@(posedge ref_clk) disable iff (!resetn)
		(wr_pend_r && addr_r == bsw_pkg::BSW_OFF_IRQ_MASK)
		|=> imask_r == $past(hwdata[bsw_pkg::BSW_NUM_EV-1:0]))
		else $error("mask write lost");
	// interrupt

	// every event pulse leaves its interrupt status bit set
	AST_IST_SET: assert property (@(posedge ref_clk) disable iff (!resetn)
		(ev_vec != '0) |=> ((ist_r & $past(ev_vec)) == $past(ev_vec)))
		else $error("event missing from interrupt status");

	// a read of the interrupt status empties it when no event arrives
	AST_IST_CLR: assert property (@(posedge ref_clk) disable iff (!resetn)
		(rd_ist_r && ev_vec == '0) |=> ist_r == '0)
		else $error("interrupt status not cleared by read");

	// an unmasked status bit raises the interrupt one cycle later
	AST_IRQ_HIGH: assert property (@(posedge ref_clk) disable iff (!resetn)
		(|(ist_r & imask_r)) |=> irq)
		else $error("interrupt not raised");

	// no unmasked status bit means no interrupt
	AST_IRQ_LOW: assert property (@(posedge ref_clk) disable iff (!resetn)
		!(|(ist_r & imask_r)) |=> !irq)
		else $error("interrupt raised without cause");
	// timing

	// the timing output follows the field one cycle late
	AST_SEL_TIM: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ3
		resetn |=> select_timing == $past(timing_r))
		else $error("timing output does not follow field");

	// the last capture edge after release takes the synchronised strap
	AST_STRAP_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn) // RQ5
		in_reset_r |=> strap_r == $past(strap_sync_r[1]))
		else $error("strap not captured at release");
endmodule // bsw_status_reg

/* logic/bsw_pkg.sv */
// bus status word package: offsets, field positions, reset values, event carrier
// assumes a single 40 MHz clock domain and an AHB-Lite register bus
package bsw_pkg;
	// register byte offsets
	localparam logic [7:0] BSW_OFF_STATUS   = 8'h00;
	localparam logic [7:0] BSW_OFF_READBACK = 8'h04;
	localparam logic [7:0] BSW_OFF_IRQ_STAT = 8'h08;
	localparam logic [7:0] BSW_OFF_IRQ_MASK = 8'h0c;
	// status word field positions
	localparam int BSW_FBB_BIT    = 7;
	localparam int BSW_TIM_LO     = 9;
	localparam int BSW_TIM_HI     = 10;
	localparam int BSW_STA_BIT    = 11;
	localparam int BSW_RTA_BIT    = 12;
	localparam int BSW_RMA_BIT    = 13;
	localparam int BSW_PERR_BIT   = 14;
	localparam int BSW_SERR_BIT   = 15;
	localparam int BSW_STRAP_BIT  = 0;
	// writable (clear on one) bits and constant bits
	localparam logic [15:0] BSW_W1C_MASK = 16'hf800;
	localparam logic        BSW_FBB_RST  = 1'b1;
	// select-response timing codes
	localparam logic [1:0] BSW_TIM_FAST   = 2'h0;
	localparam logic [1:0] BSW_TIM_MEDIUM = 2'h1;
	localparam logic [1:0] BSW_TIM_SLOW   = 2'h2;
	// interrupt status layout: one bit per abort or error event
	localparam int BSW_NUM_EV = 5;
	// ahb transfer type
	localparam logic [1:0] BSW_HTRANS_NONSEQ = 2'h2;
	// abort and error events from the bus engine, one-cycle pulses
	typedef struct packed {
		logic sig_serr;
		logic det_perr;
		logic rcv_master_abort;
		logic rcv_target_abort;
		logic sig_target_abort;
	} bsw_events_s;
endpackage

/* dv/bsw_ahb_host.sv */
// ahb-lite host model standing in for the bridge that reads and clears the status word
// assumes one slave whose hreadyout is the bus hready, single word transfers only
`timescale 1ns/10ps
module bsw_ahb_host (
	input  wire logic        ref_clk, // bus clock
	input  wire logic        hready,  // bus ready
	input  wire logic [31:0] hrdata,  // slave read data
	output logic             hsel,    // slave select
	output logic [7:0]       haddr,   // byte address
	output logic [1:0]       htrans,  // transfer type
	output logic             hwrite,  // write flag
	output logic [2:0]       hsize,   // always a word
	output logic [31:0]      hwdata   // write data
);
	// idle bus from time zero
	initial begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
	end
	// one transfer; waits on hready with no assumed latency, the bench watchdog ends a hang
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= bsw_pkg::BSW_HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge ref_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= w ? d : ~hwdata;
		do @(posedge ref_clk); while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~hwdata; // stale data must not look valid after the data phase
	endtask
endmodule // bsw_ahb_host

/* dv/testbench.sv */
// self-checking bench for the bus status word bank
// assumes the host model drives the bus and the bench drives strap and event pulses
`timescale 1ns/10ps
module testbench;
	logic                ref_clk, resetn, timing_strap_pin, hsel, hwrite;
	logic                hreadyout, hresp, irq;
	logic [7:0]          haddr;
	logic [1:0]          htrans, select_timing;
	logic [2:0]          hsize;
	logic [31:0]         hwdata, hrdata, q;
	bsw_pkg::bsw_events_s events;
	int                  num_errors, compares;
	bsw_ahb_host host_u (.ref_clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	bsw_status_reg dut_u (.ref_clk(ref_clk), .resetn(resetn), .timing_strap_pin(timing_strap_pin),
		.events(events), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq(irq), .select_timing(select_timing));
	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;
	// verdict and end of run
	task automatic close_out();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a);
		host_u.xfer(a, 1'b0, 32'h00000000, q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		host_u.xfer(a, 1'b1, d, dummy);
	endtask
	// strap is set on the edge that asserts reset and held well past release
	task automatic do_reset(input logic s);
		@(posedge ref_clk);
		resetn <= 1'b0;
		timing_strap_pin <= s;
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask
	// strap level decides the timing field; read-only and reserved bits ignore writes
	task automatic t_strap(input logic s, input logic [1:0] tim);
		logic [31:0] exp;
		exp = {16'h0000, 5'h00, tim, 1'b0, bsw_pkg::BSW_FBB_RST, 7'h00};
		do_reset(s);
		rd(bsw_pkg::BSW_OFF_STATUS);
		chk(q, exp);
		chk({30'h0, select_timing}, {30'h0, tim});
		chk({30'h0, hreadyout, hresp}, 32'h00000002); // ready and okay
		rd(bsw_pkg::BSW_OFF_READBACK);
		chk(q, {31'h0, s});
		timing_strap_pin <= ~s; // late strap change must not reach the field
		wr(bsw_pkg::BSW_OFF_STATUS, 32'hffffffff);
		rd(bsw_pkg::BSW_OFF_STATUS);
		chk(q, exp);
	endtask
	// each event sets its own sticky flag; clears act only on bits written as one
	task automatic t_flags();
		logic [31:0] exp;
		do_reset(1'b0);
		exp = 32'h00000280;
		for (int i = 0; i < bsw_pkg::BSW_NUM_EV; i++) begin
			@(posedge ref_clk);
			events <= bsw_pkg::bsw_events_s'(5'h01 << i);
			@(posedge ref_clk);
			events <= '0;
			exp[bsw_pkg::BSW_STA_BIT + i] = 1'b1;
			rd(bsw_pkg::BSW_OFF_STATUS);
			chk(q, exp);
		end
		chk({31'h0, irq}, 32'h0); // masked events keep the interrupt low
		wr(bsw_pkg::BSW_OFF_STATUS, 32'h00000000);
		rd(bsw_pkg::BSW_OFF_STATUS);
		chk(q, 32'h0000fa80);
		wr(bsw_pkg::BSW_OFF_STATUS, 32'h00004000);
		rd(bsw_pkg::BSW_OFF_STATUS);
		chk(q, 32'h0000ba80);
		wr(bsw_pkg::BSW_OFF_STATUS, 32'h00003800);
		rd(bsw_pkg::BSW_OFF_STATUS);
		chk(q, 32'h00008280);
		wr(bsw_pkg::BSW_OFF_IRQ_MASK, 32'h0000001f);
		repeat (2) @(posedge ref_clk);
		#1 chk({31'h0, irq}, 32'h1);
		rd(bsw_pkg::BSW_OFF_IRQ_STAT);
		chk(q, 32'h0000001f);
		rd(bsw_pkg::BSW_OFF_IRQ_STAT);
		chk(q, 32'h00000000);
		#1 chk({31'h0, irq}, 32'h0);
		rd(bsw_pkg::BSW_OFF_IRQ_MASK); // leaves nonzero read data before the unmapped read
		chk(q, 32'h0000001f);
		rd(8'h10); // unmapped place reads zero
		chk(q, 32'h00000000);
	endtask
	// stimulus; inputs valued at time zero
	initial begin
		ref_clk = 1'b0;
		resetn = 1'b0;
		timing_strap_pin = 1'b0;
		events = '0;
		num_errors = 0;
		compares = 0;
		t_strap(1'b0, bsw_pkg::BSW_TIM_MEDIUM);
		t_strap(1'b1, bsw_pkg::BSW_TIM_SLOW);
		t_flags();
		close_out();
	end
	// watchdog well beyond the hundred or so cycles the tests need
	initial begin
		#200000;
		num_errors++;
		close_out();
	end
endmodule // testbench
